// ==== rtl/gtcs_pkg.sv ====
//  Function
// RULE1 - low period register holds period bits 15:0
// RULE2 - high register bits 6:0 extend period to 23
// RULE3 - slot rate is slow clock over period
// RULE4 - reset period 0x2710: 100 Hz from 1 MHz
// RULE5 - writing control bit 15 restores defaults, halts core
// RULE6 - soft reset leaves host register port working
// RULE7 - clock source field picks internal/external clocks
// RULE8 - pin select 00/01/10 routes pins 0/1/2
// RULE9 - pin select 11 routes pin 3
// RULE10 - slow bit picks 32 kHz or 1 MHz
// RULE11 - period counter restarts on reaching period
package gtcs_pkg;
   localparam logic [15:0] PERIOD_LOW_ADDR  = 16'h000d;
   localparam logic [15:0] PERIOD_HIGH_ADDR = 16'h000e;
   localparam logic [15:0] SYS_CTRL_ADDR    = 16'h000f;
   localparam logic [15:0] PERIOD_LOW_RST   = 16'h2710;
   localparam logic [6:0]  PERIOD_HIGH_RST  = 7'h00;
   localparam int          SOFT_RESTART_POS = 15;
   localparam int          CLK_SRC_LSB      = 8;
   localparam int          PIN_SEL_LSB      = 6;
   localparam int          SLOW_SRC_POS     = 2;
   localparam int          OSC_1M_EN_POS    = 1;
   localparam int          OSC_32K_EN_POS   = 0;
   localparam logic [1:0]  CLK_SRC_RST      = 2'h0;
   localparam logic [1:0]  PIN_SEL_RST      = 2'h0;
   localparam logic [1:0]  SRC_INTERNAL     = 2'h0;
   localparam logic [1:0]  SRC_EXT_LF       = 2'h1;
   localparam logic [1:0]  SRC_EXT_HF       = 2'h2;
   localparam logic [1:0]  SRC_EXT_HF_DIV   = 2'h3;
   localparam int          PIN_32K          = 4;
   localparam int          PIN_1M           = 5;
   localparam int          PIN_HF           = 6;
   localparam logic [7:0]  LF_FROM_HF_DIV   = 8'h20;
   typedef logic [22:0] gtcs_period_t;
endpackage

// ==== rtl/gtcs_slot_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface gtcs_slot_if;
   logic                  lf_tick;
   logic                  halt;
   gtcs_pkg::gtcs_period_t period;
   logic                  slot_start;
   modport ctrl    (output lf_tick, output halt, output period, input slot_start);
   modport counter (input lf_tick, input halt, input period, output slot_start);
endinterface
`default_nettype wire

// ==== rtl/gtcs_period_counter.sv ====
`timescale 1ns/100ps
`default_nettype none
module gtcs_period_counter (
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        ce,
   gtcs_slot_if.counter     slot
);
   gtcs_pkg::gtcs_period_t cnt;
   logic                   start;
   // 24-bit compare so the top count cannot wrap; period 0 behaves as 1
   wire logic last = ({1'b0, cnt} + 24'h000001) >= {1'b0, slot.period};
   wire gtcs_pkg::gtcs_period_t next_cnt =
      slot.halt ? 23'h000000 :
      (slot.lf_tick ? (last ? 23'h000000 : cnt + 23'h000001) : cnt); // RULE11
   wire logic next_start = !slot.halt && slot.lf_tick && last; // RULE3

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt   <= 23'h000000;
         start <= 1'b0;
      end else if (ce) begin
         cnt   <= next_cnt;
         start <= next_start;
      end
   end
   assign slot.slot_start = start;

   slot_wrap_a: assert property (@(posedge clock) disable iff (!nrst) // RULE11
      ce && slot.lf_tick && !slot.halt && last |=> start && cnt == 23'h000000)
      else $error("period counter did not restart at period");
   slot_cause_a: assert property (@(posedge clock) disable iff (!nrst) // RULE3
      $rose(start) |-> $past(slot.lf_tick) && !$past(slot.halt))
      else $error("slot start without slow clock tick");
   halt_clear_a: assert property (@(posedge clock) disable iff (!nrst) // RULE5
      ce && slot.halt |=> cnt == 23'h000000 && !start)
      else $error("halt did not clear the period counter");
   count_step_a: assert property (@(posedge clock) disable iff (!nrst) // RULE11
      ce && slot.lf_tick && !slot.halt && !last |=> cnt == $past(cnt) + 23'h000001)
      else $error("period counter did not advance on tick");
   slot_seen_c: cover property (@(posedge clock) disable iff (!nrst) $rose(start));
endmodule
`default_nettype wire

// ==== rtl/gtcs_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module gtcs_top (
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic [3:0]  gpio_in,
   input  wire logic        osc_32k_clk,
   input  wire logic        osc_1m_clk,
   input  wire logic        osc_hf_clk,
   output logic             osc_32k_en,
   output logic             osc_1m_en,
   output logic             hf_external,
   output logic             hf_tick,
   output logic             lf_tick,
   output logic             core_reset,
   output logic             slot_start
);
   logic [15:0] period_count_low_bits;
   logic [6:0]  period_count_high_bits;
   logic [1:0]  clock_source_select;
   logic [1:0]  external_clock_pin_select;
   logic        slow_clock_source_bit;
   logic [6:0]  sync1;
   logic [6:0]  sync2;
   logic [6:0]  sync3;
   logic [7:0]  div_cnt;

   // pins and oscillators are foreign to this clock: two flops before use
   wire logic [6:0] raw_in = {osc_hf_clk, osc_1m_clk, osc_32k_clk, gpio_in};
   wire logic [6:0] rise   = sync2 & ~sync3;

   wire logic wr_low   = reg_wr && (reg_addr == gtcs_pkg::PERIOD_LOW_ADDR);
   wire logic wr_high  = reg_wr && (reg_addr == gtcs_pkg::PERIOD_HIGH_ADDR);
   wire logic wr_ctl   = reg_wr && (reg_addr == gtcs_pkg::SYS_CTRL_ADDR);
   wire logic soft_req = wr_ctl && reg_wdata[gtcs_pkg::SOFT_RESTART_POS]; // RULE5

   wire logic ext_rise = rise[external_clock_pin_select]; // RULE8 RULE9
   wire logic int_lf   = slow_clock_source_bit ? rise[gtcs_pkg::PIN_1M]
                                               : rise[gtcs_pkg::PIN_32K]; // RULE10
   wire logic hf_rise  = clock_source_select[1] ? ext_rise : rise[gtcs_pkg::PIN_HF]; // RULE7
   wire logic div_mode = clock_source_select == gtcs_pkg::SRC_EXT_HF_DIV;
   wire logic div_last = div_cnt == (gtcs_pkg::LF_FROM_HF_DIV - 8'h01);
   wire logic div_tick = div_mode && hf_rise && div_last;
   wire logic [7:0] next_div = (soft_req || !div_mode) ? 8'h00 :
      (hf_rise ? (div_last ? 8'h00 : div_cnt + 8'h01) : div_cnt);
   wire logic next_lf =
      (clock_source_select == gtcs_pkg::SRC_EXT_LF) ? ext_rise :
      (div_mode ? div_tick : int_lf); // RULE7

   wire logic [15:0] ctl_word = {6'h00, clock_source_select, external_clock_pin_select,
                                 3'h0, slow_clock_source_bit, osc_1m_en, osc_32k_en};
   wire logic [15:0] next_rdata =
      (reg_addr == gtcs_pkg::PERIOD_LOW_ADDR)  ? period_count_low_bits :
      (reg_addr == gtcs_pkg::PERIOD_HIGH_ADDR) ? {9'h000, period_count_high_bits} :
      (reg_addr == gtcs_pkg::SYS_CTRL_ADDR)    ? ctl_word : 16'h0000;

   gtcs_slot_if slot_bus ();
   assign slot_bus.lf_tick = lf_tick;
   assign slot_bus.halt    = soft_req; // RULE5
   assign slot_bus.period  = {period_count_high_bits, period_count_low_bits}; // RULE2
   assign slot_start       = slot_bus.slot_start;
   assign hf_external      = clock_source_select[1];

   gtcs_period_counter u_counter (
      .clock (clock),
      .nrst  (nrst),
      .ce    (ce),
      .slot  (slot_bus.counter)
   );

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sync1 <= 7'h00;
         sync2 <= 7'h00;
         sync3 <= 7'h00;
      end else if (ce) begin
         sync1 <= raw_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // soft reset wins over any field written in the same word
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         period_count_low_bits     <= gtcs_pkg::PERIOD_LOW_RST; // RULE4
         period_count_high_bits    <= gtcs_pkg::PERIOD_HIGH_RST;
         clock_source_select       <= gtcs_pkg::CLK_SRC_RST;
         external_clock_pin_select <= gtcs_pkg::PIN_SEL_RST;
         slow_clock_source_bit     <= 1'b0;
         osc_1m_en                 <= 1'b0;
         osc_32k_en                <= 1'b0;
      end else if (ce && soft_req) begin
         period_count_low_bits     <= gtcs_pkg::PERIOD_LOW_RST; // RULE5 RULE4
         period_count_high_bits    <= gtcs_pkg::PERIOD_HIGH_RST;
         clock_source_select       <= gtcs_pkg::CLK_SRC_RST;
         external_clock_pin_select <= gtcs_pkg::PIN_SEL_RST;
         slow_clock_source_bit     <= 1'b0;
         osc_1m_en                 <= 1'b0;
         osc_32k_en                <= 1'b0;
      end else if (ce) begin
         if (wr_low) begin
            period_count_low_bits <= reg_wdata; // RULE1
         end
         if (wr_high) begin
            period_count_high_bits <= reg_wdata[6:0]; // RULE2
         end
         if (wr_ctl) begin
            clock_source_select       <= reg_wdata[gtcs_pkg::CLK_SRC_LSB +: 2]; // RULE7
            external_clock_pin_select <= reg_wdata[gtcs_pkg::PIN_SEL_LSB +: 2]; // RULE8
            slow_clock_source_bit     <= reg_wdata[gtcs_pkg::SLOW_SRC_POS]; // RULE10
            osc_1m_en                 <= reg_wdata[gtcs_pkg::OSC_1M_EN_POS];
            osc_32k_en                <= reg_wdata[gtcs_pkg::OSC_32K_EN_POS];
         end
      end
   end

   // host port state is outside the soft reset so reads keep answering
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         reg_rdata  <= 16'h0000;
         div_cnt    <= 8'h00;
         lf_tick    <= 1'b0;
         hf_tick    <= 1'b0;
         core_reset <= 1'b0;
      end else if (ce) begin
         if (reg_rd) begin
            reg_rdata <= next_rdata; // RULE6
         end
         div_cnt    <= next_div;
         lf_tick    <= next_lf;
         hf_tick    <= hf_rise;
         core_reset <= soft_req;
      end
   end

   soft_default_a: assert property (@(posedge clock) disable iff (!nrst) // RULE5
      ce && soft_req |=> {period_count_high_bits, period_count_low_bits} == 23'h002710
         && clock_source_select == 2'h0 && core_reset)
      else $error("soft reset did not restore defaults");
   host_alive_a: assert property (@(posedge clock) disable iff (!nrst) // RULE6
      ce && soft_req && reg_rd && reg_addr == 16'h000f |=> reg_rdata == $past(ctl_word))
      else $error("read lost during soft reset");
   pin_route_a: assert property (@(posedge clock) disable iff (!nrst) // RULE9
      ce && clock_source_select == 2'h1 && external_clock_pin_select == 2'h3
         |=> lf_tick == $past(sync2[3] && !sync3[3]))
      else $error("external slow clock not taken from pin 3");
   slow_pick_a: assert property (@(posedge clock) disable iff (!nrst) // RULE10
      ce && clock_source_select == 2'h0 && slow_clock_source_bit
         |=> lf_tick == $past(rise[5]))
      else $error("1 MHz source not selected");
   div_tick_a: assert property (@(posedge clock) disable iff (!nrst) // RULE7
      ce && div_mode && hf_rise && div_cnt == 8'h1f |=> lf_tick && div_cnt == 8'h00)
      else $error("derived slow clock divider wrong");
   low_write_a: assert property (@(posedge clock) disable iff (!nrst) // RULE1
      ce && wr_low && !soft_req ##1 ce && reg_rd && reg_addr == 16'h000d
         |=> reg_rdata == $past(reg_wdata, 2))
      else $error("lower period readback mismatch");
   ce_freeze_a: assert property (@(posedge clock) disable iff (!nrst) // RULE1 RULE2
      !ce |=> $stable({period_count_high_bits, period_count_low_bits}))
      else $error("period changed while clock enable low");
   hf_route_a: assert property (@(posedge clock) disable iff (!nrst) // RULE7
      ce && clock_source_select[1] |=> hf_tick == $past(ext_rise))
      else $error("external fast clock not routed");
   div_clear_a: assert property (@(posedge clock) disable iff (!nrst) // RULE5
      ce && soft_req |=> div_cnt == 8'h00)
      else $error("soft reset did not clear the divider");
   high_field_a: assert property (@(posedge clock) disable iff (!nrst) // RULE2
      ce && reg_rd && reg_addr == gtcs_pkg::PERIOD_HIGH_ADDR |=> reg_rdata[15:7] == 9'h000)
      else $error("reserved upper period bits not zero");
   soft_c: cover property (@(posedge clock) disable iff (!nrst) ce && soft_req);
   ext_lf_c: cover property (@(posedge clock) disable iff (!nrst)
      clock_source_select == 2'h1 && lf_tick);
   div_c: cover property (@(posedge clock) disable iff (!nrst) div_tick);
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic        ce = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [6:0]  pins = 7'h00;
   logic        osc_32k_en, osc_1m_en, hf_external, hf_tick, lf_tick, core_reset, slot_start;
   logic [31:0] seed = 32'h70e7;
   logic [15:0] v, d;
   logic [15:0] cfgs [2] = '{16'h0286, 16'h0001};
   int          bad_count = 0, n_compared = 0, cyc = 0;
   int          lf_n = 0, hf_n = 0, cr_n = 0, gap = 0, last = 0, l0, h0, sl_n = 0;

   always #2 clock = ~clock;

   // pin order follows the package pin indices, so one vector feeds all sources
   gtcs_top gtcs_top_inst (.clock(clock), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .gpio_in(pins[3:0]), .osc_32k_clk(pins[4]), .osc_1m_clk(pins[5]),
      .osc_hf_clk(pins[6]), .osc_32k_en(osc_32k_en), .osc_1m_en(osc_1m_en),
      .hf_external(hf_external), .hf_tick(hf_tick), .lf_tick(lf_tick),
      .core_reset(core_reset), .slot_start(slot_start));

   always @(negedge clock) begin
      cyc++;
      if (lf_tick === 1'b1) lf_n++;
      if (hf_tick === 1'b1) hf_n++;
      if (core_reset === 1'b1) cr_n++;
      // gap in slow ticks between slot starts, blind to the counter's start phase
      if (slot_start === 1'b1) begin
         sl_n++;
         gap = lf_n - last;
         last = lf_n;
      end
      if (cyc == 20000) begin
         bad_count++;
         test_done();
      end
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [15:0] ctrl_exp(input logic [15:0] w);
      return w & 16'h03c7;
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] w);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = w;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [15:0] a);
      @(negedge clock);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      v = reg_rdata;
   endtask

   // write then read in the very next cycle, address held throughout
   task automatic wr_rd(input logic [15:0] a, input logic [15:0] w);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = w;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      v = reg_rdata;
   endtask

   // slow edges: sources are sampled levels and need several cycles per phase
   task automatic edges(input int idx, input int n);
      repeat (n) begin
         pins[idx] = 1'b1;
         repeat (5) @(negedge clock);
         pins[idx] = 1'b0;
         repeat (5) @(negedge clock);
      end
      repeat (6) @(negedge clock);
   endtask

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(negedge clock);
      nrst = 1'b1;
      rd(gtcs_pkg::PERIOD_LOW_ADDR);
      check("period_low", v, 16'h2710);
      rd(gtcs_pkg::PERIOD_HIGH_ADDR);
      check("period_high", v, 16'h0000);
      rd(gtcs_pkg::SYS_CTRL_ADDR);
      check("system_control", v, 16'h0000);
      wr(gtcs_pkg::SYS_CTRL_ADDR, 16'h0006);
      // ascending periods only, so the count never lies beyond a new period
      for (int i = 0; i < 2; i++) begin
         d = (i == 0) ? 16'h0001 : 16'h0002 + 16'(xs() % 5);
         wr(gtcs_pkg::PERIOD_LOW_ADDR, d);
         edges(gtcs_pkg::PIN_1M, 3 * d + 2);
         check("slot_gap", gap, d);
      end
      $display("test slot period done");
      for (int i = 0; i < 8; i++) begin
         d = 16'(xs());
         wr_rd(gtcs_pkg::PERIOD_LOW_ADDR, d);
         check("period_low", v, d);
         wr(gtcs_pkg::PERIOD_HIGH_ADDR, d);
         rd(gtcs_pkg::PERIOD_HIGH_ADDR);
         check("period_high", v, {9'h000, d[6:0]});
         wr(gtcs_pkg::SYS_CTRL_ADDR, d & 16'h7fff);
         rd(gtcs_pkg::SYS_CTRL_ADDR);
         check("system_control", v, ctrl_exp(d));
         check("hf_external", hf_external, d[9]);
         check("osc_enables", {osc_1m_en, osc_32k_en}, d[1:0]);
      end
      wr(16'h0010, 16'hffff);
      rd(16'h0010);
      check("unmapped", v, 16'h0000);
      $display("test registers done");
      for (int k = 0; k < 4; k++) begin
         wr(gtcs_pkg::SYS_CTRL_ADDR, 16'h0100 | 16'(k << 6));
         l0 = lf_n;
         edges(k, 3);
         check("lf_ticks_pin", lf_n - l0, 3);
      end
      for (int i = 0; i < 2; i++) begin
         wr(gtcs_pkg::SYS_CTRL_ADDR, cfgs[i]);
         l0 = lf_n;
         h0 = hf_n;
         for (int k = 2; k < 7; k++) edges(k, 2);
         check("hf_ticks", hf_n - h0, 2);
         check("lf_ticks", lf_n - l0, 2);
      end
      // 64 fast edges give two slow ticks whatever phase the divider holds
      wr(gtcs_pkg::SYS_CTRL_ADDR, 16'h0346);
      l0 = lf_n;
      edges(1, 64);
      check("lf_from_hf", lf_n - l0, 2);
      // clock enable low: writes and pin edges must leave no trace
      ce = 1'b0;
      l0 = lf_n;
      h0 = hf_n;
      wr(gtcs_pkg::PERIOD_LOW_ADDR, ~d);
      edges(1, 40);
      ce = 1'b1;
      rd(gtcs_pkg::PERIOD_LOW_ADDR);
      check("ce_hold", v, d);
      check("ce_ticks", (lf_n - l0) + (hf_n - h0), 0);
      $display("test clock select done");
      l0 = cr_n;
      wr(gtcs_pkg::SYS_CTRL_ADDR, 16'h8346);
      rd(gtcs_pkg::SYS_CTRL_ADDR);
      check("core_reset", cr_n - l0, 1);
      check("system_control", v, 16'h0000);
      check("osc_1m_en", osc_1m_en, 1'b0);
      rd(gtcs_pkg::PERIOD_LOW_ADDR);
      check("period_low", v, 16'h2710);
      wr(gtcs_pkg::SYS_CTRL_ADDR, 16'h0003);
      wr(gtcs_pkg::PERIOD_LOW_ADDR, 16'h0004);
      edges(gtcs_pkg::PIN_32K, 2);
      // soft reset and a read of the same register taken at one edge
      @(negedge clock);
      reg_addr = gtcs_pkg::SYS_CTRL_ADDR;
      reg_wdata = 16'h8000;
      reg_wr = 1'b1;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      check("read_in_reset", reg_rdata, 16'h0003);
      check("osc_32k_en", osc_32k_en, 1'b0);
      // a counter left at 2 would give two slots in 7 ticks, a cleared one gives one
      wr(gtcs_pkg::PERIOD_LOW_ADDR, 16'h0004);
      l0 = sl_n;
      edges(gtcs_pkg::PIN_32K, 7);
      check("slots_after_reset", sl_n - l0, 1);
      $display("test soft reset done");
      test_done();
   end
endmodule
`default_nettype wire
